/* core/srlm_map.svh */
// register offsets, field positions and reset values of the alignment monitor
`ifndef SRLM_MAP_SVH
`define SRLM_MAP_SVH
`define SRLM_ADDR_W          8
`define SRLM_DATA_W          8
`define SRLM_OFF_IRQ_EN      8'h20
`define SRLM_OFF_IRQ_STAT    8'h24
`define SRLM_OFF_TGT_FRM     8'h31
`define SRLM_OFF_TGT_LO      8'h32
`define SRLM_OFF_TGT_HI      8'h33
`define SRLM_OFF_MEAS_LO     8'h34
`define SRLM_OFF_MEAS_HI     8'h35
`define SRLM_OFF_TALLY       8'h36
`define SRLM_OFF_PHASE_LO    8'h37
`define SRLM_OFF_PHASE_HI    8'h38
`define SRLM_OFF_JIT_TOL     8'h39
`define SRLM_OFF_CTRL        8'h3A
`define SRLM_JIT_BIT         4
`define SRLM_VAL_W           12
`define SRLM_FRM_W           5
`define SRLM_TOL_W           6
`define SRLM_TOL_IGNORE      2
`define SRLM_MEAS_ZERO_LSBS  2
`define SRLM_RESET_VAL       8'h00
`define SRLM_LMFC_PERIOD     16'h0400
`define SRLM_FRAME_CYCLES    8'h04
`endif

/* core/srlm_pkg.sv */
// types shared by the alignment monitor
package srlm_pkg;
	// alignment mode field encodings
	typedef enum logic [1:0] {
		SRLM_MODE_MONITOR = 2'b00,
		SRLM_MODE_CONT    = 2'b01,
		SRLM_MODE_ONCE    = 2'b10,
		SRLM_MODE_RSVD    = 2'b11
	} srlm_mode_t;
	// measurement sequencer, gray coded
	typedef enum logic [1:0] {
		SRLM_ST_IDLE  = 2'b00,
		SRLM_ST_COUNT = 2'b01,
		SRLM_ST_DONE  = 2'b11
	} srlm_state_t;
	// one register access from software
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} srlm_bus_t;
endpackage : srlm_pkg

/* core/srlm_edge_sync.sv */
// two-stage synchroniser with rising edge pulse for the reference pin
`timescale 1ns/10ps
module srlm_edge_sync (
	// clock and reset
	input  wire logic clk,
	input  wire logic resetn,
	// pin and event
	input  wire logic pin_in,
	output logic      rise_pulse
);
	logic meta_r;
	logic sync_r;
	logic last_r;

	// first stage feeds only the second
	always_ff @(posedge clk) begin
		if (!resetn) begin
			meta_r <= 1'b0;
			sync_r <= 1'b0;
			last_r <= 1'b0;
		end else begin
			meta_r <= pin_in;
			sync_r <= meta_r;
			last_r <= sync_r;
		end
	end

	assign rise_pulse = sync_r & ~last_r;
endmodule : srlm_edge_sync

/* core/srlm_lmfc_gen.sv */
// local multiframe clock counter with realignment load
`timescale 1ns/10ps
`include "srlm_map.svh"
module srlm_lmfc_gen #(
	parameter logic [15:0] PERIOD = `SRLM_LMFC_PERIOD
) (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        resetn,
	// realignment
	input  wire logic        realign,
	input  wire logic [15:0] load_val,
	// lmfc state
	output logic             lmfc_edge,
	output logic [15:0]      cycles_to_edge
);
	logic [15:0] cnt_r;
	logic        edge_r;

	// down count to the next lmfc rising edge; a realign reloads the distance
	always_ff @(posedge clk) begin
		if (!resetn) begin
			cnt_r  <= 16'h0000;
			edge_r <= 1'b0;
		end else if (realign) begin
			cnt_r  <= load_val;
			edge_r <= 1'b0;
		end else if (cnt_r == 16'h0000) begin
			cnt_r  <= PERIOD - 16'h0001;
			edge_r <= 1'b1;
		end else begin
			cnt_r  <= cnt_r - 16'h0001;
			edge_r <= 1'b0;
		end
	end

	assign lmfc_edge      = edge_r;
	assign cycles_to_edge = cnt_r;
endmodule : srlm_lmfc_gen

/* core/srlm_monitor.sv */
// sysref to lmfc alignment and monitor top level with register port
//
// Overview of operation
// - 12-bit target delay in DAC clocks, split low byte and high nibble.
// - measured sysref-to-lmfc delay is 12 bits, two lsbs read zero.
// - writing a measured-delay or phase register freezes delay, phase, tally.
// - 8-bit sysref pulse tally; any write to it clears it.
// - ref_edge_phase reported as 12-bit thermometer code, low byte, high nibble.
// - timing variation above the 6-bit tolerance raises the jitter condition.
// - tolerance low two bits ignored, four-clock granularity.
// - 2-bit mode; monitor mode only measures and never realigns.
// - continuous mode realigns lmfc on every sysref pulse.
// - mode 10 realigns on next sysref only, then falls back to monitor.
// - delay, measurement, tally, phase, tolerance and mode reset to zero.
// - sticky jitter flag bit 4, write-1 clear, irq gated by enable bit 4.
// - 5-bit target delay in frames held beside the clock-unit delay.
`timescale 1ns/10ps
`include "srlm_map.svh"
module srlm_monitor #(
	parameter logic [15:0] LMFC_PERIOD  = `SRLM_LMFC_PERIOD,
	parameter logic [7:0]  FRAME_CYCLES = `SRLM_FRAME_CYCLES
) (
	// clock and reset
	input  wire logic              clk,
	input  wire logic              resetn,
	// register port
	input  wire srlm_pkg::srlm_bus_t bus,
	output logic [7:0]             rd_data,
	// reference pin and lmfc
	input  wire logic              sysref,
	output logic                   lmfc_edge,
	// interrupt
	output logic                   ref_jitter_irq
);
	////////////////////////////////////////////////////////////////////////////
	// registers and state
	logic [11:0]          lmfc_target_delay_r;
	logic [4:0]           lmfc_target_frames_r;
	logic [5:0]           ref_jitter_tolerance_r;
	srlm_pkg::srlm_mode_t mode_r;
	logic                 ref_jitter_irq_enable_r;
	logic                 ref_jitter_flag_r;
	logic [7:0]           tally_r;
	logic [11:0]          meas_live_r;
	logic [11:0]          phase_live_r;
	logic [11:0]          meas_hold_r;
	logic [11:0]          phase_hold_r;
	logic [7:0]           tally_hold_r;
	logic [11:0]          meas_cnt_r;
	srlm_pkg::srlm_state_t st_r;
	logic [15:0]          prev_pos_r;
	logic                 have_prev_r;
	logic [7:0]           rd_data_r;
	logic                 ref_rise;
	logic                 realign;
	logic [15:0]          pos;
	logic [15:0]          diff;
	logic                 jitter_evt;
	logic                 freeze_wr;

	function automatic logic wr_at(input srlm_pkg::srlm_bus_t b, input logic [7:0] a);
		wr_at = b.wr && (b.addr == a);
	endfunction : wr_at

	// count of set bits is the lmfc position, saturated at 12
	function automatic logic [11:0] thermo(input logic [15:0] v);
		logic [11:0] t;
		t = 12'h000;
		for (int i = 0; i < 12; i++) begin
			if (v > 16'(i))
				t[i] = 1'b1;
		end
		thermo = t;
	endfunction : thermo

	////////////////////////////////////////////////////////////////////////////
	// pin synchroniser and lmfc counter
	srlm_edge_sync u_sync (
		.clk        (clk),
		.resetn     (resetn),
		.pin_in     (sysref),
		.rise_pulse (ref_rise)
	);

	// realign only in continuous or single-shot mode
	assign realign = ref_rise && (mode_r == srlm_pkg::SRLM_MODE_CONT ||
	                              mode_r == srlm_pkg::SRLM_MODE_ONCE);

	srlm_lmfc_gen #(
		.PERIOD (LMFC_PERIOD)
	) u_lmfc (
		.clk            (clk),
		.resetn         (resetn),
		.realign        (realign),
		.load_val       (16'(lmfc_target_frames_r) * 16'(FRAME_CYCLES)
		                 + 16'(lmfc_target_delay_r)),
		.lmfc_edge      (lmfc_edge),
		.cycles_to_edge (pos)
	);

	////////////////////////////////////////////////////////////////////////////
	// configuration writes; reserved bits never stored
	always_ff @(posedge clk) begin
		if (!resetn) begin
			lmfc_target_delay_r     <= 12'h000;
			lmfc_target_frames_r    <= 5'h00;
			ref_jitter_tolerance_r  <= 6'h00;
			ref_jitter_irq_enable_r <= 1'b0;
		end else begin
			if (wr_at(bus, `SRLM_OFF_TGT_LO))
				lmfc_target_delay_r[7:0] <= bus.wdata;
			if (wr_at(bus, `SRLM_OFF_TGT_HI))
				lmfc_target_delay_r[11:8] <= bus.wdata[3:0];
			if (wr_at(bus, `SRLM_OFF_TGT_FRM))
				lmfc_target_frames_r <= bus.wdata[4:0];
			if (wr_at(bus, `SRLM_OFF_JIT_TOL))
				ref_jitter_tolerance_r <= bus.wdata[5:0];
			if (wr_at(bus, `SRLM_OFF_IRQ_EN))
				ref_jitter_irq_enable_r <= bus.wdata[`SRLM_JIT_BIT];
		end
	end

	// mode; a software write wins over the automatic fall back
	always_ff @(posedge clk) begin
		if (!resetn)
			mode_r <= srlm_pkg::SRLM_MODE_MONITOR;
		else if (wr_at(bus, `SRLM_OFF_CTRL))
			mode_r <= srlm_pkg::srlm_mode_t'(bus.wdata[1:0]);
		else if (ref_rise && mode_r == srlm_pkg::SRLM_MODE_ONCE)
			mode_r <= srlm_pkg::SRLM_MODE_MONITOR;
	end

	////////////////////////////////////////////////////////////////////////////
	// pulse tally, cleared by any write
	always_ff @(posedge clk) begin
		if (!resetn)
			tally_r <= 8'h00;
		else if (wr_at(bus, `SRLM_OFF_TALLY))
			tally_r <= 8'h00;
		else if (ref_rise)
			tally_r <= tally_r + 8'h01;
	end

	// delay measurement from sysref rise to the following lmfc rise
	always_ff @(posedge clk) begin
		if (!resetn) begin
			st_r        <= srlm_pkg::SRLM_ST_IDLE;
			meas_cnt_r  <= 12'h000;
			meas_live_r <= 12'h000;
		end else begin
			case (st_r)
				srlm_pkg::SRLM_ST_IDLE, srlm_pkg::SRLM_ST_DONE: begin
					st_r <= srlm_pkg::SRLM_ST_IDLE;
					// the event cycle itself is the first clock of the delay
					if (ref_rise) begin
						st_r       <= srlm_pkg::SRLM_ST_COUNT;
						meas_cnt_r <= 12'h001;
					end
				end
				srlm_pkg::SRLM_ST_COUNT: begin
					if (meas_cnt_r != 12'hFFF)
						meas_cnt_r <= meas_cnt_r + 12'h001;
					if (lmfc_edge) begin
						meas_live_r <= {meas_cnt_r[11:2], 2'b00};
						st_r        <= srlm_pkg::SRLM_ST_DONE;
					end
				end
				default: st_r <= srlm_pkg::SRLM_ST_IDLE;
			endcase
		end
	end

	// phase of the sysref event within the lmfc period
	always_ff @(posedge clk) begin
		if (!resetn)
			phase_live_r <= 12'h000;
		else if (ref_rise)
			phase_live_r <= thermo(pos);
	end

	////////////////////////////////////////////////////////////////////////////
	// jitter check: compare lmfc position at successive sysref edges
	assign diff = (pos > prev_pos_r) ? pos - prev_pos_r : prev_pos_r - pos;
	assign jitter_evt = ref_rise && have_prev_r &&
	                    diff > 16'({ref_jitter_tolerance_r[5:2], 2'b00});

	always_ff @(posedge clk) begin
		if (!resetn) begin
			prev_pos_r  <= 16'h0000;
			have_prev_r <= 1'b0;
		end else if (ref_rise) begin
			prev_pos_r  <= pos;
			have_prev_r <= 1'b1;
		end
	end

	// sticky flag: a new event beats a same-cycle clear
	always_ff @(posedge clk) begin
		if (!resetn)
			ref_jitter_flag_r <= 1'b0;
		else if (jitter_evt)
			ref_jitter_flag_r <= 1'b1;
		else if (wr_at(bus, `SRLM_OFF_IRQ_STAT) && bus.wdata[`SRLM_JIT_BIT])
			ref_jitter_flag_r <= 1'b0;
	end

	assign ref_jitter_irq = ref_jitter_flag_r & ref_jitter_irq_enable_r;

	////////////////////////////////////////////////////////////////////////////
	// readback freeze on write to any measured-delay or phase register
	assign freeze_wr = wr_at(bus, `SRLM_OFF_MEAS_LO) || wr_at(bus, `SRLM_OFF_MEAS_HI) ||
	                   wr_at(bus, `SRLM_OFF_PHASE_LO) || wr_at(bus, `SRLM_OFF_PHASE_HI);

	always_ff @(posedge clk) begin
		if (!resetn) begin
			meas_hold_r  <= 12'h000;
			phase_hold_r <= 12'h000;
			tally_hold_r <= 8'h00;
		end else if (freeze_wr) begin
			meas_hold_r  <= meas_live_r;
			phase_hold_r <= phase_live_r;
			tally_hold_r <= tally_r;
		end else if (wr_at(bus, `SRLM_OFF_TALLY)) begin
			tally_hold_r <= 8'h00;
		end
	end

	// read data stand for one cycle only; unmapped reads return zero
	always_ff @(posedge clk) begin
		if (!resetn)
			rd_data_r <= 8'h00;
		else if (!bus.rd)
			rd_data_r <= 8'h00;
		else begin
			case (bus.addr)
				`SRLM_OFF_IRQ_EN:   rd_data_r <= {3'b000, ref_jitter_irq_enable_r, 4'h0};
				`SRLM_OFF_IRQ_STAT: rd_data_r <= {3'b000, ref_jitter_flag_r, 4'h0};
				`SRLM_OFF_TGT_FRM:  rd_data_r <= {3'b000, lmfc_target_frames_r};
				`SRLM_OFF_TGT_LO:   rd_data_r <= lmfc_target_delay_r[7:0];
				`SRLM_OFF_TGT_HI:   rd_data_r <= {4'h0, lmfc_target_delay_r[11:8]};
				`SRLM_OFF_MEAS_LO:  rd_data_r <= meas_hold_r[7:0];
				`SRLM_OFF_MEAS_HI:  rd_data_r <= {4'h0, meas_hold_r[11:8]};
				`SRLM_OFF_TALLY:    rd_data_r <= tally_hold_r;
				`SRLM_OFF_PHASE_LO: rd_data_r <= phase_hold_r[7:0];
				`SRLM_OFF_PHASE_HI: rd_data_r <= {4'h0, phase_hold_r[11:8]};
				`SRLM_OFF_JIT_TOL:  rd_data_r <= {2'b00, ref_jitter_tolerance_r};
				`SRLM_OFF_CTRL:     rd_data_r <= {6'h00, mode_r};
				default:            rd_data_r <= 8'h00;
			endcase
		end
	end

	assign rd_data = rd_data_r;

	////////////////////////////////////////////////////////////////////////////
	// checks
	property p_tally_clear;
		@(posedge clk) disable iff (!resetn)
		wr_at(bus, `SRLM_OFF_TALLY) |=> tally_r == 8'h00;
	endproperty
	a_tally_clear: assert property (p_tally_clear) else $error("tally not cleared");

	property p_meas_lsbs;
		@(posedge clk) disable iff (!resetn)
		meas_live_r[1:0] == 2'b00 && meas_hold_r[1:0] == 2'b00;
	endproperty
	a_meas_lsbs: assert property (p_meas_lsbs) else $error("measured lsbs not zero");

	property p_freeze;
		@(posedge clk) disable iff (!resetn)
		freeze_wr |=> meas_hold_r == $past(meas_live_r) && tally_hold_r == $past(tally_r);
	endproperty
	a_freeze: assert property (p_freeze) else $error("freeze did not capture");

	property p_jit_set;
		@(posedge clk) disable iff (!resetn)
		jitter_evt |=> ref_jitter_flag_r;
	endproperty
	a_jit_set: assert property (p_jit_set) else $error("jitter flag not set");

	property p_jit_quiet;
		@(posedge clk) disable iff (!resetn)
		ref_rise && have_prev_r && diff <= 16'({ref_jitter_tolerance_r[5:2], 2'b00})
		&& !ref_jitter_flag_r |=> !ref_jitter_flag_r;
	endproperty
	a_jit_quiet: assert property (p_jit_quiet) else $error("jitter within window flagged");

	property p_irq_gate;
		@(posedge clk) disable iff (!resetn)
		ref_jitter_irq |-> ref_jitter_irq_enable_r && ref_jitter_flag_r;
	endproperty
	a_irq_gate: assert property (p_irq_gate) else $error("irq without enable");

	property p_monitor_hold;
		@(posedge clk) disable iff (!resetn)
		(mode_r == srlm_pkg::SRLM_MODE_MONITOR || mode_r == srlm_pkg::SRLM_MODE_RSVD) |-> !realign;
	endproperty
	a_monitor_hold: assert property (p_monitor_hold) else $error("realign in monitor mode");

	property p_cont;
		@(posedge clk) disable iff (!resetn)
		ref_rise && mode_r == srlm_pkg::SRLM_MODE_CONT |=> mode_r == srlm_pkg::SRLM_MODE_CONT
		|| $past(bus.wr);
	endproperty
	a_cont: assert property (p_cont) else $error("continuous mode lost");

	property p_once;
		@(posedge clk) disable iff (!resetn)
		ref_rise && mode_r == srlm_pkg::SRLM_MODE_ONCE && !bus.wr
		|-> realign ##1 mode_r == srlm_pkg::SRLM_MODE_MONITOR;
	endproperty
	a_once: assert property (p_once) else $error("single shot did not fall back");
endmodule : srlm_monitor

/* tb/srlm_ref_source.sv */
// reference pulse source standing on the far side of the monitor
`timescale 1ns/10ps
module srlm_ref_source (
	// clock
	input  wire logic clk,
	// reference pin
	output logic      sysref
);
	int n_sent = 0;
	// pin rests low between pulses
	initial sysref = 1'b0;
	// pulse w edges wide; w of two or more so the synchroniser never misses it
	task automatic fire(int w);
		sysref <= 1'b1;
		n_sent++;
		repeat (w) @(posedge clk);
		sysref <= 1'b0;
	endtask : fire
endmodule : srlm_ref_source

/* tb/srlm_monitor_test.sv */
// self-checking bench for the alignment monitor
`timescale 1ns/10ps
module srlm_monitor_test;
	localparam logic [15:0] PER = 16'h0200;
	localparam int          P   = 512;
	logic                clk, resetn, sysref, lmfc_edge, ref_jitter_irq;
	logic [7:0]          rd_data, lo, hi;
	srlm_pkg::srlm_bus_t bus;
	int                  n_fail = 0, n_compared = 0, cyc = 0, t_rise = 0, t_lmfc = 0;
	int                  ld, d, f, v, t0;
	int                  wa [6]  = '{8'h20, 8'h31, 8'h32, 8'h33, 8'h39, 8'h3A};
	int                  wm [6]  = '{8'h10, 8'h1F, 8'hFF, 8'h0F, 8'h3F, 8'h03};
	int                  ra [15] = '{8'h20, 8'h24, 8'h31, 8'h32, 8'h33, 8'h34, 8'h35, 8'h36,
		8'h37, 8'h38, 8'h39, 8'h3A, 8'h00, 8'h3B, 8'hFF};
	int                  md [2]  = '{8'h00, 8'h03};

	srlm_monitor #(.LMFC_PERIOD(PER), .FRAME_CYCLES(8'h04)) dut (.clk(clk), .resetn(resetn),
		.bus(bus), .rd_data(rd_data), .sysref(sysref), .lmfc_edge(lmfc_edge),
		.ref_jitter_irq(ref_jitter_irq));
	srlm_ref_source src (.clk(clk), .sysref(sysref));

	////////////////////////////////////////////////////////////
	// clock
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// edge counter and time of latest lmfc pulse, updated late so readers agree
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (lmfc_edge === 1'b1)
			t_lmfc <= cyc;
	end

	////////////////////////////////////////////////////////////
	task automatic chk(string nm, int e, logic [11:0] g);
		n_compared++;
		if (g !== e[11:0]) begin
			n_fail++;
			$display("BAD %s expected %0h seen %0h", nm, e, g);
		end
	endtask : chk
	task automatic wr(logic [7:0] a, logic [7:0] wd);
		@(posedge clk);
		bus <= '{addr: a, wdata: wd, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		bus.wr <= 1'b0;
	endtask : wr
	// read data stand only in the cycle after the strobe
	task automatic rd(logic [7:0] a, output logic [7:0] q);
		@(posedge clk);
		bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		bus.rd <= 1'b0;
		#1;
		q = rd_data;
	endtask : rd
	task automatic rc(logic [7:0] a, int e);
		logic [7:0] q;
		rd(a, q);
		chk($sformatf("reg%0h", a), e, {4'h0, q});
	endtask : rc
	// pulse no earlier than edge t, so spacing between pulses is exact
	task automatic pulse(int t);
		do @(posedge clk); while (cyc < t);
		t_rise = cyc;
		src.fire(2);
	endtask : pulse
	// bounded wait for the next lmfc pulse
	task automatic next_edge();
		int old;
		old = t_lmfc;
		for (int k = 0; k < 2 * P && t_lmfc == old; k++) begin
			@(posedge clk);
			#1;
		end
	endtask : next_edge
	task automatic irq_is(int e);
		repeat (2) @(posedge clk);
		#1;
		chk("irq", e, {11'h000, ref_jitter_irq});
	endtask : irq_is
	task automatic end_sim();
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : end_sim

	////////////////////////////////////////////////////////////
	// watchdog, far beyond the fewer than eight thousand edges the tests need
	initial begin
		repeat (40000) @(posedge clk);
		n_fail++;
		end_sim();
	end
	// main sequence
	initial begin
		bus = '0;
		resetn = 1'b0;
		v = $urandom(32'h796B);
		repeat (16) @(posedge clk);
		resetn <= 1'b1;
		foreach (ra[i]) rc(ra[i][7:0], 0);
		foreach (wa[i]) begin
			v = $urandom;
			wr(wa[i][7:0], v[7:0]);
			rc(wa[i][7:0], v & wm[i]);
		end
		// continuous mode: every pulse realigns to frames and clocks target
		wr(8'h3A, 8'h01);
		repeat (2) begin
			d = $urandom_range(399, 256);
			f = $urandom_range(7, 0);
			wr(8'h32, d[7:0]);
			wr(8'h33, d[15:8]);
			wr(8'h31, f[7:0]);
			ld = d + 4 * f;
			next_edge();
			pulse(0);
			next_edge();
			chk("realign", 1, {11'h000, (t_lmfc - t_rise) inside {[ld + 3 : ld + 6]}});
			wr(8'h34, 8'h00);
			rc(8'h34, (ld + 2) & 8'hFC);
			rc(8'h35, ((ld + 2) >> 8) & 4'hF);
		end
		// single shot realigns once, then the mode reads monitor
		wr(8'h3A, 8'h02);
		next_edge();
		pulse(0);
		next_edge();
		chk("once", 1, {11'h000, (t_lmfc - t_rise) inside {[ld + 3 : ld + 6]}});
		rc(8'h3A, 0);
		// monitor and reserved modes keep the lmfc grid; pulse placed off grid
		foreach (md[i]) begin
			wr(8'h3A, md[i][7:0]);
			next_edge();
			t0 = t_lmfc;
			repeat (50) @(posedge clk);
			pulse(0);
			next_edge();
			next_edge();
			chk("grid", 0, (t_lmfc - t0) % P);
		end
		// held tally changes only when frozen; a write to it clears it
		wr(8'h37, 8'h00);
		rc(8'h36, src.n_sent);
		pulse(0);
		// lmfc position at the event, from the following lmfc pulse
		next_edge();
		v = t_lmfc - t_rise - 4;
		rc(8'h36, src.n_sent - 1);
		wr(8'h38, 8'h00);
		rc(8'h36, src.n_sent);
		rd(8'h37, lo);
		rd(8'h38, hi);
		chk("phase", (1 << ((v > 12) ? 12 : v)) - 1, {hi[3:0], lo});
		wr(8'h36, 8'h5A);
		wr(8'h35, 8'h00);
		rc(8'h36, 0);
		// jitter: tolerance 7 acts as 4, so a shift of 6 flags
		wr(8'h39, 8'h07);
		wr(8'h20, 8'h00);
		pulse(0);
		t0 = t_rise;
		pulse(t0 + P);
		repeat (8) @(posedge clk);
		wr(8'h24, 8'h10);
		pulse(t0 + 2 * P);
		repeat (8) @(posedge clk);
		rc(8'h24, 0);
		pulse(t0 + 3 * P + 6);
		repeat (8) @(posedge clk);
		rc(8'h24, 8'h10);
		irq_is(0);
		wr(8'h20, 8'h10);
		irq_is(1);
		wr(8'h24, 8'h10);
		irq_is(0);
		rc(8'h24, 0);
		end_sim();
	end
endmodule : srlm_monitor_test
